/* hw/filter_array_pkg.sv */
package filter_array_pkg;

   // ****************************************************************
   // Widths and formats
   // ****************************************************************
   localparam int DATA_W     = 12;
   localparam int COEF_W     = 10;
   localparam int CHAIN_W    = 16;
   localparam int PROD_W     = DATA_W + COEF_W;
   localparam int SUM_W      = 27;
   localparam int COEF_FRAC  = 9;
   localparam int CHAIN_FRAC = 4;
   localparam int CHAIN_SHL  = COEF_FRAC - CHAIN_FRAC;
   localparam int MAT_LSB    = COEF_FRAC;
   localparam int CHAIN_LSB  = CHAIN_SHL;
   localparam int HI_PINS    = 4;

   // ****************************************************************
   // Tap lines and coefficient slots (row base plus offset 0..2 for slot 1..3)
   // ****************************************************************
   localparam int A_TAPS = 4;
   localparam int B_TAPS = 9;
   localparam int C_TAPS = 3;
   localparam int N_MULT = 9;
   localparam int ROW_A  = 0;
   localparam int ROW_B  = 3;
   localparam int ROW_C  = 6;

   localparam logic [SUM_W-1:0] ROUND_HALF = 27'h0000010;

   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [11:0] CONFIG_OFFSET      = 12'h000;
   localparam logic [11:0] STATUS_OFFSET      = 12'h004;
   localparam int          MODE_LSB           = 0;
   localparam int          STATUS_SETTLED_BIT = 2;
   localparam logic [3:0]  FLUSH_CYCLES       = 4'hd;

   typedef enum logic [1:0] {
      MODE_MATRIX  = 2'h0,
      MODE_FIR     = 2'h1,
      MODE_CONV3X3 = 2'h2,
      MODE_CONV4X2 = 2'h3
   } mode_t;

   localparam mode_t CONFIG_RESET = MODE_MATRIX;

   typedef enum logic [1:0] {
      WSEL_HOLD  = 2'h0,
      WSEL_SLOT1 = 2'h1,
      WSEL_SLOT2 = 2'h2,
      WSEL_SLOT3 = 2'h3
   } wsel_t;

endpackage : filter_array_pkg

/* hw/nine_multiplier_filter_array.sv */
//
// Function
// - FIR impulse to response centre: nine stages
// - Chain input reaches chain output in four
// - 3x3 mode: three pixels a clock, nine products
// - 3x3 sum plus chain input, rounded, 5-7 clocks
// - 3x3 mode: three tap rows shift each clock
// - 3x3 output: rows times slots 3,2,1 plus chain
// - 3x3 impulse to response centre: six stages
// - 4x2 mode: A and B rows, 5-8 clocks
// - 4x2 mode ignores slot C2
// - 4x2 mode: two tap rows shift each clock
// - Mode select registered, used next clock
// - Outputs invalid until pipeline flushed after change
// - Mode codes: matrix, FIR, 3x3, 4x2
// - Write select picks slot 1, 2, 3
// - Three coefficients latched on next clock
// - Data latched, shifted per tap in filter modes
// - Filter modes: X and upper Y are chain input
// - Filter modes: Z and lower Y chain output
// - Matrix mode: registered X, Y, Z outputs
// - Chain output half-LSB rounded to sixteen bits
// - Integer data, fractional coefficients, 12.4 chain
// - Matrix: column sums, five clocks, truncated
//
`timescale 1ns/1ps
`default_nettype none

module nine_multiplier_filter_array
   import filter_array_pkg::*;
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output var  logic [31:0]          prdata,
   output var  logic                 pready,
   output var  logic                 pslverr,
   input  wire logic [DATA_W-1:0]    data_a,
   input  wire logic [DATA_W-1:0]    data_b,
   input  wire logic [DATA_W-1:0]    data_c,
   input  wire logic [COEF_W-1:0]    coef_port_row_a,
   input  wire logic [COEF_W-1:0]    coef_port_row_b,
   input  wire logic [COEF_W-1:0]    coef_port_row_c,
   input  wire logic [1:0]           coef_write_select,
   input  wire logic [DATA_W-1:0]    shared_x_chain_pins,
   output var  logic [DATA_W-1:0]    shared_x_chain_drive,
   output var  logic                 shared_x_chain_oe,
   input  wire logic [HI_PINS-1:0]   shared_y_chain_pins,
   output var  logic [DATA_W-1:0]    shared_y_chain_drive,
   output var  logic                 shared_y_chain_oe,
   output var  logic [DATA_W-1:0]    shared_z_chain_pins
);

   // ****************************************************************
   // Helpers
   // ****************************************************************
   function automatic logic signed [PROD_W-1:0] mult(
      input logic signed [DATA_W-1:0] pix,
      input logic signed [COEF_W-1:0] k
   );
      mult = pix * k;
   endfunction : mult
   function automatic logic signed [SUM_W-1:0] widen(
      input logic signed [PROD_W-1:0] p
   );
      widen = SUM_W'(p);
   endfunction : widen

   // ****************************************************************
   // Register bus and configuration
   // ****************************************************************
   mode_t       mode_ff,      nxt_mode;
   logic [3:0]  settle_ff,    nxt_settle;
   logic [31:0] prdata_ff,    nxt_prdata;
   logic        pready_ff,    nxt_pready;
   logic        pslverr_ff,   nxt_pslverr;
   logic        wr_cfg;
   logic        settled;
   assign wr_cfg  = psel & penable & pready_ff & pwrite
                  & (paddr == CONFIG_OFFSET);
   assign settled = (settle_ff == FLUSH_CYCLES);
   always_comb begin
      nxt_pready  = psel & ~penable;
      nxt_prdata  = prdata_ff;
      nxt_pslverr = 1'b0;
      nxt_mode    = mode_ff;
      nxt_settle  = settle_ff;
      // Answer is prepared in setup so access completes with no wait
      if (psel && !penable) begin
         unique case (paddr)
            CONFIG_OFFSET: nxt_prdata = {30'h0, mode_ff};
            STATUS_OFFSET: nxt_prdata = {29'h0, settled, mode_ff};
            default: begin
               nxt_prdata  = 32'h0;
               nxt_pslverr = 1'b1;
            end
         endcase
      end
      if (wr_cfg) begin
         nxt_mode = mode_t'(pwdata[MODE_LSB +: 2]);
      end
      // Only a real change restarts the flush count
      if (wr_cfg && (pwdata[MODE_LSB +: 2] != mode_ff)) begin
         nxt_settle = 4'h0;
      end else if (!settled) begin
         nxt_settle = settle_ff + 4'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_ff    <= CONFIG_RESET;
         settle_ff  <= 4'h0;
         prdata_ff  <= 32'h0;
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
      end else begin
         mode_ff    <= nxt_mode;
         settle_ff  <= nxt_settle;
         prdata_ff  <= nxt_prdata;
         pready_ff  <= nxt_pready;
         pslverr_ff <= nxt_pslverr;
      end
   end

   assign prdata  = prdata_ff;
   assign pready  = pready_ff;
   assign pslverr = pslverr_ff;

   // ****************************************************************
   // Coefficient storage
   // ****************************************************************
   logic signed [COEF_W-1:0] coef_ff [N_MULT];
   logic signed [COEF_W-1:0] nxt_coef [N_MULT];
   always_comb begin
      int slot;
      slot = 0;
      for (int i = 0; i < N_MULT; i++) begin
         nxt_coef[i] = coef_ff[i];
      end
      if (wsel_t'(coef_write_select) != WSEL_HOLD) begin
         slot = int'(coef_write_select) - 1;
         nxt_coef[ROW_A + slot] = coef_port_row_a;
         nxt_coef[ROW_B + slot] = coef_port_row_b;
         nxt_coef[ROW_C + slot] = coef_port_row_c;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < N_MULT; i++) coef_ff[i] <= '0;
      end else begin
         for (int i = 0; i < N_MULT; i++) coef_ff[i] <= nxt_coef[i];
      end
   end

   // ****************************************************************
   // Tap lines, multipliers and adders
   // ****************************************************************
   logic signed [DATA_W-1:0]  a_sh_ff [A_TAPS];
   logic signed [DATA_W-1:0]  b_sh_ff [B_TAPS];
   logic signed [DATA_W-1:0]  c_sh_ff [C_TAPS];
   logic signed [DATA_W-1:0]  nxt_a_sh [A_TAPS];
   logic signed [DATA_W-1:0]  nxt_b_sh [B_TAPS];
   logic signed [DATA_W-1:0]  nxt_c_sh [C_TAPS];
   logic signed [DATA_W-1:0]  opnd [N_MULT];
   logic signed [PROD_W-1:0]  prod_ff [N_MULT];
   logic signed [PROD_W-1:0]  nxt_prod [N_MULT];
   logic signed [SUM_W-1:0]   sum_ff [3];
   logic signed [SUM_W-1:0]   nxt_sum [3];
   logic signed [SUM_W-1:0]   add_ff [3];
   logic signed [SUM_W-1:0]   nxt_add [3];
   logic signed [CHAIN_W-1:0] cas_in_ff, cas_d_ff;
   logic signed [CHAIN_W-1:0] nxt_cas_in, nxt_cas_d;
   always_comb begin
      // Newest sample sits at index 0; every line moves each clock
      nxt_a_sh[0] = data_a;
      nxt_b_sh[0] = data_b;
      nxt_c_sh[0] = data_c;
      for (int i = 1; i < A_TAPS; i++) nxt_a_sh[i] = a_sh_ff[i-1];
      for (int i = 1; i < B_TAPS; i++) nxt_b_sh[i] = b_sh_ff[i-1];
      for (int i = 1; i < C_TAPS; i++) nxt_c_sh[i] = c_sh_ff[i-1];
      for (int i = 0; i < N_MULT; i++) opnd[i] = '0;
      unique case (mode_ff)
         MODE_MATRIX: begin
            for (int j = 0; j < 3; j++) begin
               opnd[ROW_A + j] = a_sh_ff[0];
               opnd[ROW_B + j] = b_sh_ff[0];
               opnd[ROW_C + j] = c_sh_ff[0];
            end
         end
         MODE_FIR: begin
            // B tap line supplies six delayed samples
            for (int j = 0; j < 3; j++) begin
               opnd[ROW_A + j] = a_sh_ff[2-j];
               opnd[ROW_B + j] = b_sh_ff[5-j];
               opnd[ROW_C + j] = b_sh_ff[8-j];
            end
         end
         MODE_CONV3X3: begin
            for (int j = 0; j < 3; j++) begin
               opnd[ROW_A + j] = a_sh_ff[2-j];
               opnd[ROW_B + j] = b_sh_ff[2-j];
               opnd[ROW_C + j] = c_sh_ff[2-j];
            end
         end
         MODE_CONV4X2: begin
            for (int j = 0; j < 3; j++) begin
               opnd[ROW_A + j] = a_sh_ff[2-j];
               opnd[ROW_B + j] = b_sh_ff[2-j];
            end
            opnd[ROW_C]     = b_sh_ff[3];
            opnd[ROW_C + 2] = a_sh_ff[3];
            // Slot C2 operand stays zero, so its coefficient is moot
            opnd[ROW_C + 1] = '0;
         end
      endcase
      for (int i = 0; i < N_MULT; i++) begin
         nxt_prod[i] = mult(opnd[i], coef_ff[i]);
      end
      for (int j = 0; j < 3; j++) nxt_sum[j] = '0;
      if (mode_ff == MODE_MATRIX) begin
         for (int j = 0; j < 3; j++) begin
            nxt_sum[j] = widen(prod_ff[ROW_A + j])
                       + widen(prod_ff[ROW_B + j])
                       + widen(prod_ff[ROW_C + j]);
         end
      end else begin
         for (int i = 0; i < N_MULT; i++) begin
            nxt_sum[0] = nxt_sum[0] + widen(prod_ff[i]);
         end
      end
      // Chain word is taken from the shared pins every clock
      nxt_cas_in = {shared_x_chain_pins, shared_y_chain_pins};
      nxt_cas_d  = cas_in_ff;
      for (int j = 0; j < 3; j++) nxt_add[j] = sum_ff[j];
      if (mode_ff != MODE_MATRIX) begin
         nxt_add[0] = sum_ff[0]
                    + (SUM_W'(cas_d_ff) <<< CHAIN_SHL)
                    + ROUND_HALF;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < A_TAPS; i++) a_sh_ff[i] <= '0;
         for (int i = 0; i < B_TAPS; i++) b_sh_ff[i] <= '0;
         for (int i = 0; i < C_TAPS; i++) c_sh_ff[i] <= '0;
         for (int i = 0; i < N_MULT; i++) prod_ff[i] <= '0;
         for (int j = 0; j < 3; j++) sum_ff[j] <= '0;
         for (int j = 0; j < 3; j++) add_ff[j] <= '0;
         cas_in_ff <= '0;
         cas_d_ff  <= '0;
      end else begin
         for (int i = 0; i < A_TAPS; i++) a_sh_ff[i] <= nxt_a_sh[i];
         for (int i = 0; i < B_TAPS; i++) b_sh_ff[i] <= nxt_b_sh[i];
         for (int i = 0; i < C_TAPS; i++) c_sh_ff[i] <= nxt_c_sh[i];
         for (int i = 0; i < N_MULT; i++) prod_ff[i] <= nxt_prod[i];
         for (int j = 0; j < 3; j++) sum_ff[j] <= nxt_sum[j];
         for (int j = 0; j < 3; j++) add_ff[j] <= nxt_add[j];
         cas_in_ff <= nxt_cas_in;
         cas_d_ff  <= nxt_cas_d;
      end
   end

   // ****************************************************************
   // Output pins
   // ****************************************************************
   logic [DATA_W-1:0]  x_ff, y_ff, z_ff;
   logic [DATA_W-1:0]  nxt_x, nxt_y, nxt_z;
   logic               x_oe_ff, y_oe_ff, nxt_x_oe, nxt_y_oe;
   logic [CHAIN_W-1:0] chain_out;
   // Overflow wraps: the chain word has no headroom above 12.4
   assign chain_out = add_ff[0][CHAIN_LSB +: CHAIN_W];
   always_comb begin
      if (mode_ff == MODE_MATRIX) begin
         nxt_x    = add_ff[0][MAT_LSB +: DATA_W];
         nxt_y    = add_ff[1][MAT_LSB +: DATA_W];
         nxt_z    = add_ff[2][MAT_LSB +: DATA_W];
         nxt_x_oe = 1'b1;
         nxt_y_oe = 1'b1;
      end else begin
         nxt_x    = '0;
         nxt_y    = {8'h00, chain_out[HI_PINS-1:0]};
         nxt_z    = chain_out[CHAIN_W-1:HI_PINS];
         nxt_x_oe = 1'b0;
         nxt_y_oe = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         x_ff    <= '0;
         y_ff    <= '0;
         z_ff    <= '0;
         x_oe_ff <= 1'b0;
         y_oe_ff <= 1'b0;
      end else begin
         x_ff    <= nxt_x;
         y_ff    <= nxt_y;
         z_ff    <= nxt_z;
         x_oe_ff <= nxt_x_oe;
         y_oe_ff <= nxt_y_oe;
      end
   end

   assign shared_x_chain_drive = x_ff;
   assign shared_x_chain_oe    = x_oe_ff;
   assign shared_y_chain_drive = y_ff;
   assign shared_y_chain_oe    = y_oe_ff;
   assign shared_z_chain_pins  = z_ff;

   // ****************************************************************
   // Checks
   // ****************************************************************
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   mode_apply_a: assert property (wr_cfg |=> mode_ff == $past(pwdata[1:0]))
      else $error("mode not taken from write");
   flush_start_a: assert property (
      wr_cfg && pwdata[1:0] != mode_ff |=> !settled [*8])
      else $error("settled too early after mode change");
   coef_slot_a: assert property (
      coef_write_select == 2'h2 |=>
      coef_ff[ROW_C + 1] == $past(coef_port_row_c)
      && coef_ff[ROW_A + 1] == $past(coef_port_row_a))
      else $error("slot two not loaded");
   coef_hold_a: assert property (
      coef_write_select == 2'h0 |=>
      coef_ff[ROW_A] == $past(coef_ff[ROW_A])
      && coef_ff[ROW_C + 2] == $past(coef_ff[ROW_C + 2]))
      else $error("coefficient changed on hold");
   tap_shift_a: assert property (
      a_sh_ff[0] == $past(data_a) && a_sh_ff[2] == $past(a_sh_ff[1])
      && b_sh_ff[8] == $past(b_sh_ff[7]))
      else $error("tap line misplaced");
   chain_delay_a: assert property (
      cas_d_ff == $past({shared_x_chain_pins, shared_y_chain_pins}, 2))
      else $error("chain input delay wrong");
   slot_c2_a: assert property (
      mode_ff == MODE_CONV4X2 |=> prod_ff[ROW_C + 1] == '0)
      else $error("slot C2 used in 4x2 mode");
   filter_pins_a: assert property (
      mode_ff != MODE_MATRIX [*2] |-> !x_oe_ff && !y_oe_ff
      && z_ff == $past(chain_out[CHAIN_W-1:HI_PINS]))
      else $error("filter pin routing wrong");
   matrix_pins_a: assert property (
      (presetn && mode_ff == MODE_MATRIX) [*2] |-> x_oe_ff && y_oe_ff
      && y_ff == $past(add_ff[1][MAT_LSB +: DATA_W]))
      else $error("matrix outputs wrong");
   fir_held_c: cover property (mode_ff == MODE_FIR && settled);
   mode_change_c: cover property (wr_cfg && pwdata[1:0] != mode_ff);
   coef_sweep_c: cover property (
      coef_write_select == 2'h1 ##1 coef_write_select == 2'h2
      ##1 coef_write_select == 2'h3);
   bus_error_c: cover property (pready_ff && pslverr_ff);

endmodule : nine_multiplier_filter_array

`default_nettype wire

/* tb/chain_neighbour.sv */
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Neighbour filter that feeds the chain input pins
// ****************************************************************
module chain_neighbour (
   input  wire logic [15:0] chain_word,
   input  wire logic [11:0] x_drive,
   input  wire logic        x_oe,
   input  wire logic [11:0] y_drive,
   input  wire logic        y_oe,
   output var  logic [11:0] x_wire,
   output var  logic [3:0]  y_wire
);
   // Backs off while the device owns the shared pins in matrix mode,
   // so the wire never sees two drivers at once
   always_comb begin
      x_wire = x_oe ? x_drive : chain_word[15:4];
      y_wire = y_oe ? y_drive[11:8] : chain_word[3:0];
   end
endmodule : chain_neighbour

`default_nettype wire

/* tb/tb_nine_multiplier_filter_array.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_nine_multiplier_filter_array import filter_array_pkg::*; ;
   typedef struct {int due; logic mat; logic [35:0] v;} note_t;
   typedef struct {logic rd; logic [32:0] v;} bus_note_t;

   logic        pclk = 1'b0;
   logic        presetn, psel, penable, pwrite, pready, pslverr;
   logic        x_oe, y_oe;
   logic [11:0] paddr, da, db, dc, x_pins, x_drv, y_drv, z_pins;
   logic [31:0] pwdata, prdata;
   logic [9:0]  ka, kb, kc;
   logic [1:0]  wsel;
   logic [3:0]  y_pins;
   logic [15:0] chain_word;
   int          cyc = 0;
   int          mismatches = 0;
   int          num_checks = 0;
   int          k[9];
   int          h[3][9];
   int          rb[3] = '{ROW_A, ROW_B, ROW_C};
   note_t       sq[$];
   bus_note_t   rq[$];

   nine_multiplier_filter_array u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .data_a(da), .data_b(db),
      .data_c(dc), .coef_port_row_a(ka), .coef_port_row_b(kb),
      .coef_port_row_c(kc), .coef_write_select(wsel),
      .shared_x_chain_pins(x_pins), .shared_x_chain_drive(x_drv),
      .shared_x_chain_oe(x_oe), .shared_y_chain_pins(y_pins),
      .shared_y_chain_drive(y_drv), .shared_y_chain_oe(y_oe),
      .shared_z_chain_pins(z_pins));

   chain_neighbour u_neighbour (
      .chain_word(chain_word), .x_drive(x_drv), .x_oe(x_oe),
      .y_drive(y_drv), .y_oe(y_oe), .x_wire(x_pins), .y_wire(y_pins));

   // ****************************************************************
   // Clock, timeout, checking
   // ****************************************************************
   always #5 pclk = ~pclk;

   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc > 4000) begin
         mismatches++;
         give_verdict();
      end
   end

   function automatic void chk(input string nm, input logic [35:0] e,
                               input logic [35:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endfunction : chk

   task automatic give_verdict();
      if (mismatches == 0 && num_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : give_verdict

   always @(posedge pclk) begin
      bus_note_t b;
      note_t     n;
      if (psel && penable && pready === 1'b1 && rq.size() > 0) begin
         b = rq.pop_front();
         if (b.rd)
            chk("read", {3'h0, b.v}, {3'h0, pslverr, prdata});
         else
            chk("pslverr", {35'h0, b.v[32]}, {35'h0, pslverr});
      end
      #1;
      while (sq.size() > 0 && sq[0].due <= cyc) begin
         n = sq.pop_front();
         if (n.mat) begin
            chk("matrix", n.v, {x_drv, y_drv, z_pins});
            chk("matrix_oe", 36'h3, {34'h0, x_oe, y_oe});
         end else begin
            chk("chain", n.v, {18'h0, y_oe, x_oe, z_pins, y_drv[3:0]});
            chk("spare_pins", 36'h0, {16'h0, x_drv, y_drv[11:4]});
         end
      end
   end

   // ****************************************************************
   // Reference arithmetic, newest sample in column 0
   // ****************************************************************
   function automatic logic [35:0] model(input logic [1:0] m,
                                         input logic [15:0] ch);
      int          s;
      int          t;
      logic [35:0] r;
      s = 0;
      r = '0;
      case (m)
         MODE_MATRIX: begin
            for (int sl = 0; sl < 3; sl++) begin
               t = 0;
               for (int p = 0; p < 3; p++)
                  t += h[p][0] * k[rb[p] + sl];
               r[24 - 12 * sl +: 12] = t[20:9];
            end
         end
         MODE_FIR: begin
            for (int j = 0; j < 9; j++)
               s += h[0][j] * k[rb[j / 3] + 2 - j % 3];
         end
         MODE_CONV3X3: begin
            for (int p = 0; p < 3; p++)
               for (int j = 0; j < 3; j++)
                  s += h[p][j] * k[rb[p] + 2 - j];
         end
         default: begin
            for (int p = 0; p < 2; p++)
               for (int j = 0; j < 3; j++)
                  s += h[p][j] * k[rb[p] + 2 - j];
            s += h[0][3] * k[ROW_C + 2] + h[1][3] * k[ROW_C];
         end
      endcase
      t = s + $signed(ch) * 32 + 16;
      if (m != MODE_MATRIX)
         r = {20'h0, t[20:5]};
      return r;
   endfunction : model

   // ****************************************************************
   // Drivers
   // ****************************************************************
   task automatic apb(input logic w, input logic [11:0] ad,
                      input logic [31:0] wd, input logic [32:0] ev,
                      input logic cmp, output logic [31:0] rd);
      bus_note_t bn;
      bn.rd = cmp;
      bn.v  = ev;
      rq.push_back(bn);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= ad;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic stream(input logic [1:0] m, input int n);
      logic [11:0] a, b, c;
      logic [15:0] ch;
      note_t       e;
      for (int i = 0; i < n; i++) begin
         @(posedge pclk);
         a  = 12'($urandom);
         b  = (m == MODE_FIR) ? a : 12'($urandom);
         c  = 12'($urandom);
         ch = 16'($urandom);
         da <= a;
         db <= b;
         dc <= c;
         chain_word <= ch;
         // Junk on the coefficient ports must not disturb stored values
         ka <= 10'($urandom);
         kb <= 10'($urandom);
         kc <= 10'($urandom);
         if (i > 9) begin
            e.due = cyc + 5;
            e.mat = (m == MODE_MATRIX);
            e.v   = model(m, ch);
            sq.push_back(e);
         end
         for (int j = 8; j > 0; j--)
            for (int p = 0; p < 3; p++)
               h[p][j] = h[p][j - 1];
         h[0][0] = $signed(a);
         h[1][0] = $signed(b);
         h[2][0] = $signed(c);
      end
      repeat (8) @(posedge pclk);
   endtask : stream

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      logic [31:0] rd;
      logic [29:0] vk;
      logic [1:0]  order[4];
      int          g;
      order = '{MODE_FIR, MODE_CONV3X3, MODE_CONV4X2, MODE_MATRIX};
      {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
      {da, db, dc, ka, kb, kc, wsel, chain_word} = '0;
      void'($urandom(54));
      repeat (4) @(posedge pclk);
      chk("reset_out", 36'h0, {x_drv, y_drv, z_pins});
      presetn <= 1'b1;
      for (int sl = 1; sl < 4; sl++) begin
         @(posedge pclk);
         vk = 30'($urandom);
         wsel <= 2'(sl);
         ka   <= vk[29:20];
         kb   <= vk[19:10];
         kc   <= vk[9:0];
         k[ROW_A + sl - 1] = $signed(vk[29:20]);
         k[ROW_B + sl - 1] = $signed(vk[19:10]);
         k[ROW_C + sl - 1] = $signed(vk[9:0]);
      end
      @(posedge pclk);
      wsel <= WSEL_HOLD;
      apb(1'b0, CONFIG_OFFSET, 32'h0, 33'h0, 1'b1, rd);
      apb(1'b1, 12'h010, 32'h3, {1'b1, 32'h0}, 1'b0, rd);
      foreach (order[q]) begin
         apb(1'b1, CONFIG_OFFSET, {30'h0, order[q]}, 33'h0, 1'b0, rd);
         apb(1'b0, STATUS_OFFSET, 32'h0, {31'h0, order[q]}, 1'b1, rd);
         g = 0;
         do begin
            apb(1'b0, STATUS_OFFSET, 32'h0, 33'h0, 1'b0, rd);
            g++;
         end while (rd[STATUS_SETTLED_BIT] !== 1'b1 && g < 30);
         chk("settled", 36'h1, {35'h0, rd[STATUS_SETTLED_BIT]});
         stream(order[q], 40);
      end
      give_verdict();
   end
endmodule : tb_nine_multiplier_filter_array

`default_nettype wire
